// File: src/sgd_pkg.sv
// Operation
// [RL1] sixteen current settings by register, seven by resistor-set pin
// [RL2] selected current for the drive window, then the smaller hold current
// [RL3] hand over between transistors only once gate-source voltage shows off
// [RL4] serial variant adds a register-set digital dead time after the handshake
// [RL5] handshake may stretch dead time 100-200 ns while detection node discharges
// [RL6] strong pulldown on the opposite gate for the drive window
// [RL7] gate not at threshold when the drive window ends flags a gate fault
// [RL8] drive window never stretches pwm; a new command ends it early
// [RL9] configurer picks a window longer than the gate charge time
// [RL10] overcurrent when drain-source sense stays over trip past deglitch time
// [RL11] serial variant picks positive or negative shunt as low-side reference
// [RL12] trip level 0.06-2 V serial, 0.06-1 V hardware variant
// [RL13] every control input passes a deglitch filter before reaching gates
// [RL14] hardware variant reads current and trip level from seven-level pins
// [RL15] faults latched per half-bridge and side, shown on fault pin and status
package sgd_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned IN_DEGLITCH_NS = 50;
   localparam int unsigned IN_DEGLITCH_CYC =
      (IN_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HS_EXTRA_NS_MIN = 100;
   localparam int unsigned HS_EXTRA_NS_MAX = 200;
   localparam int unsigned PHASES = 3;
   localparam int unsigned CTRL_INPUTS = 2 * PHASES + 1;
   localparam int unsigned LEVELS_HW = 7;
   localparam logic [3:0] CURRENT_SEL_RESET = 4'hf;
   localparam logic [3:0] TRIP_SEL_RESET = 4'h7;
   // hardware levels map onto the 16-step codes; trip codes stay at or below 1 V
   localparam logic [3:0] CURRENT_HW_MAP [LEVELS_HW] =
      '{4'h0, 4'h2, 4'h5, 4'h7, 4'ha, 4'hc, 4'hf};
   localparam logic [3:0] TRIP_HW_MAP [LEVELS_HW] =
      '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
   localparam logic [1:0] SIDE_NONE = 2'h0;
   localparam logic [1:0] SIDE_HS = 2'h1;
   localparam logic [1:0] SIDE_LS = 2'h2;
   localparam logic [1:0] OC_MODE_LATCH = 2'h0;
   localparam logic [1:0] OC_MODE_REPORT = 2'h1;
   localparam logic [1:0] OC_MODE_OFF = 2'h2;
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_WAIT_OFF = 3'b010,
      ST_DEAD = 3'b100
   } sgd_state_e;
   typedef struct packed {
      logic on;
      logic drive_current;
      logic strong_pulldown;
   } sgd_gate_s;
   typedef struct packed {
      sgd_gate_s hs;
      sgd_gate_s ls;
   } sgd_phase_s;
endpackage

// File: src/sgd_sequencer.sv
module sgd_sequencer #(
   parameter int unsigned CNT_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serial_variant,
   input wire logic [2*sgd_pkg::PHASES-1:0] pwm_in,
   input wire logic fault_clear_in,
   input wire logic [2*sgd_pkg::PHASES-1:0] vgs_high_in,
   input wire logic [sgd_pkg::PHASES-1:0] highside_drain_sense_over,
   input wire logic [sgd_pkg::PHASES-1:0] shunt_positive_sense_over,
   input wire logic [sgd_pkg::PHASES-1:0] shunt_negative_sense_over,
   input wire logic lowside_monitor_reference_select,
   input wire logic [3:0] gate_current_select_reg,
   input wire logic [2:0] gate_current_select_pin,
   input wire logic [3:0] trip_level_reg,
   input wire logic [2:0] threshold_select_pin,
   input wire logic [CNT_W-1:0] drive_window_cycles,
   input wire logic [CNT_W-1:0] dead_time_cycles,
   input wire logic [CNT_W-1:0] overcurrent_deglitch_time,
   input wire logic [1:0] oc_fault_mode,
   output sgd_pkg::sgd_phase_s [sgd_pkg::PHASES-1:0] gate_q,
   output logic [3:0] gate_current_select_q,
   output logic [3:0] overcurrent_trip_level_q,
   output logic [2*sgd_pkg::PHASES-1:0] gate_fault_q,
   output logic [2*sgd_pkg::PHASES-1:0] oc_fault_q,
   output logic fault_n_q
);
   localparam int unsigned NP = sgd_pkg::PHASES;
   localparam int unsigned NS = 7 * NP + 7;
   localparam int unsigned DG_W = 8;

   function automatic logic [3:0] level_code(input logic [2:0] lvl, input logic trip);
      logic [2:0] l;
      l = (lvl > 3'h6) ? 3'h6 : lvl;
      level_code = trip ? sgd_pkg::TRIP_HW_MAP[l] : sgd_pkg::CURRENT_HW_MAP[l];
   endfunction

   // two-flop synchronisers for every pin input; meta stage read only by sync stage
   logic [NS-1:0] async_in, meta_q, sync_q;
   assign async_in = {pwm_in, fault_clear_in, vgs_high_in, highside_drain_sense_over,
                      shunt_positive_sense_over, shunt_negative_sense_over,
                      gate_current_select_pin, threshold_select_pin};
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   localparam int unsigned CTRL_INPUTS_W = sgd_pkg::CTRL_INPUTS;
   logic [CTRL_INPUTS_W-1:0] ctrl_raw;
   logic [2*NP-1:0] vgs_s;
   logic [NP-1:0] hs_over_s, sp_over_s, sn_over_s;
   logic [2:0] cur_pin_s, thr_pin_s;
   assign {ctrl_raw, vgs_s, hs_over_s, sp_over_s, sn_over_s, cur_pin_s, thr_pin_s} = sync_q;

   // control deglitch: output follows only after a stable run
   logic [CTRL_INPUTS_W-1:0] ctrl_f;
   genvar gi;
   generate
      for (gi = 0; gi < CTRL_INPUTS_W; gi++) begin : g_dg
         logic [DG_W-1:0] cnt_q, cnt_d;
         logic f_q, f_d;
         always_comb begin
            cnt_d = cnt_q;
            f_d = f_q;
            if (ctrl_raw[gi] == f_q) begin
               cnt_d = '0;
            end else if (cnt_q == DG_W'(sgd_pkg::IN_DEGLITCH_CYC - 1)) begin
               f_d = ctrl_raw[gi]; // [RL13]
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + DG_W'(1);
            end
         end
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               cnt_q <= '0;
               f_q <= 1'b0;
            end else if (ce) begin
               cnt_q <= cnt_d;
               f_q <= f_d;
            end
         end
         assign ctrl_f[gi] = f_q;
      end
   endgenerate
   logic [2*NP-1:0] pwm_f;
   logic clr_f;
   assign {pwm_f, clr_f} = ctrl_f;

   // latched shutdown stops all switching until faults are cleared
   logic shutdown;
   assign shutdown = (oc_fault_mode == sgd_pkg::OC_MODE_LATCH) && (|oc_fault_q);

   logic [2*NP-1:0] gf_set, oc_set;
   sgd_pkg::sgd_phase_s [NP-1:0] gate_d;

   generate
      for (gi = 0; gi < NP; gi++) begin : g_ph
         sgd_pkg::sgd_state_e st_q, st_d;
         logic [1:0] on_q, on_d, sw_q, sw_d, tgt;
         logic sw_on_q, sw_on_d;
         logic [1:0] tgt_prev_q;
         logic [CNT_W-1:0] win_q, win_d, dead_q, dead_d;
         logic [CNT_W-1:0] occ_q [2];
         logic [CNT_W-1:0] occ_d [2];
         logic start, win_act, hs_vgs, ls_vgs, sw_vgs;
         logic [1:0] over;
         // per-phase fault sets keep each shared vector bit to one driver
         logic [1:0] gfs, ocs;
         assign hs_vgs = vgs_s[2*gi+1];
         assign ls_vgs = vgs_s[2*gi];
         assign win_act = (win_q != '0);
         assign gf_set[2*gi+1 -: 2] = gfs;
         assign oc_set[2*gi+1 -: 2] = ocs;
         // both inputs high never drive both gates on
         always_comb begin
            if (shutdown) begin
               tgt = sgd_pkg::SIDE_NONE;
            end else begin
               unique case (pwm_f[2*gi+1 -: 2])
                  2'b10: tgt = sgd_pkg::SIDE_HS;
                  2'b01: tgt = sgd_pkg::SIDE_LS;
                  default: tgt = sgd_pkg::SIDE_NONE;
               endcase
            end
         end
         assign sw_vgs = (sw_q == sgd_pkg::SIDE_HS) ? hs_vgs : ls_vgs;
         always_comb begin
            st_d = st_q;
            on_d = on_q;
            sw_d = sw_q;
            sw_on_d = sw_on_q;
            dead_d = dead_q;
            start = 1'b0;
            unique case (st_q)
               sgd_pkg::ST_HOLD: begin
                  if (tgt != on_q) begin
                     if (on_q != sgd_pkg::SIDE_NONE) begin
                        sw_d = on_q;
                        sw_on_d = 1'b0;
                        start = 1'b1;
                     end
                     on_d = sgd_pkg::SIDE_NONE;
                     st_d = sgd_pkg::ST_WAIT_OFF;
                  end
               end
               sgd_pkg::ST_WAIT_OFF: begin
                  // waiting on measured gate voltage also absorbs the slow discharge case
                  if (!hs_vgs && !ls_vgs) begin // [RL3] [RL5]
                     dead_d = serial_variant ? dead_time_cycles : '0; // [RL4]
                     st_d = sgd_pkg::ST_DEAD;
                  end
               end
               sgd_pkg::ST_DEAD: begin
                  if (dead_q != '0) begin
                     dead_d = dead_q - CNT_W'(1); // [RL4]
                  end else begin
                     if (tgt != sgd_pkg::SIDE_NONE) begin
                        on_d = tgt;
                        sw_d = tgt;
                        sw_on_d = 1'b1;
                        start = 1'b1;
                     end
                     st_d = sgd_pkg::ST_HOLD;
                  end
               end
               default: st_d = sgd_pkg::ST_HOLD;
            endcase
         end
         // drive window: started on every gate switch, ended early by a new command
         always_comb begin
            win_d = win_q;
            gfs = 2'b00;
            if (start) begin
               win_d = drive_window_cycles; // [RL2]
            end else if (win_act && (tgt != tgt_prev_q)) begin
               win_d = '0; // [RL8]
            end else if (win_q == CNT_W'(1)) begin
               win_d = '0;
               if (sw_vgs != sw_on_q) begin
                  gfs[(sw_q == sgd_pkg::SIDE_HS) ? 1 : 0] = 1'b1; // [RL7]
               end
            end else if (win_act) begin
               win_d = win_q - CNT_W'(1);
            end
         end
         // low-side reference choice exists only on the serial variant
         assign over[1] = hs_over_s[gi] && (on_q == sgd_pkg::SIDE_HS);
         assign over[0] = ((serial_variant && lowside_monitor_reference_select)
                           ? sn_over_s[gi] : sp_over_s[gi]) // [RL11]
                          && (on_q == sgd_pkg::SIDE_LS);
         always_comb begin
            for (int k = 0; k < 2; k++) begin
               occ_d[k] = '0;
               ocs[k] = 1'b0;
               if (over[k]) begin
                  occ_d[k] = occ_q[k];
                  if (occ_q[k] >= overcurrent_deglitch_time) begin
                     ocs[k] = (oc_fault_mode != sgd_pkg::OC_MODE_OFF); // [RL10]
                  end else begin
                     occ_d[k] = occ_q[k] + CNT_W'(1);
                  end
               end
            end
         end
         always_comb begin
            gate_d[gi].hs.on = (on_q == sgd_pkg::SIDE_HS);
            gate_d[gi].ls.on = (on_q == sgd_pkg::SIDE_LS);
            gate_d[gi].hs.drive_current = win_act && (sw_q == sgd_pkg::SIDE_HS); // [RL2]
            gate_d[gi].ls.drive_current = win_act && (sw_q == sgd_pkg::SIDE_LS); // [RL2]
            gate_d[gi].hs.strong_pulldown = win_act && (sw_q == sgd_pkg::SIDE_LS); // [RL6]
            gate_d[gi].ls.strong_pulldown = win_act && (sw_q == sgd_pkg::SIDE_HS); // [RL6]
         end
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               st_q <= sgd_pkg::ST_HOLD;
               on_q <= sgd_pkg::SIDE_NONE;
               sw_q <= sgd_pkg::SIDE_NONE;
               sw_on_q <= 1'b0;
               tgt_prev_q <= sgd_pkg::SIDE_NONE;
               win_q <= '0;
               dead_q <= '0;
               occ_q[0] <= '0;
               occ_q[1] <= '0;
            end else if (ce) begin
               st_q <= st_d;
               on_q <= on_d;
               sw_q <= sw_d;
               sw_on_q <= sw_on_d;
               tgt_prev_q <= tgt;
               win_q <= win_d;
               dead_q <= dead_d;
               occ_q[0] <= occ_d[0];
               occ_q[1] <= occ_d[1];
            end
         end
      end
   endgenerate

   // fault latches: a set in the clearing cycle wins
   logic [2*NP-1:0] gf_d, oc_d;
   logic [3:0] cur_d, trip_d;
   always_comb begin
      gf_d = (clr_f ? '0 : gate_fault_q) | gf_set; // [RL15]
      oc_d = (clr_f ? '0 : oc_fault_q) | oc_set; // [RL15]
      // trip range depends on the variant through the code tables
      cur_d = serial_variant ? gate_current_select_reg // [RL1]
                             : level_code(cur_pin_s, 1'b0); // [RL14]
      trip_d = serial_variant ? trip_level_reg // [RL12]
                              : level_code(thr_pin_s, 1'b1); // [RL14]
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         gate_q <= '0;
         gate_fault_q <= '0;
         oc_fault_q <= '0;
         fault_n_q <= 1'b1;
         gate_current_select_q <= sgd_pkg::CURRENT_SEL_RESET;
         overcurrent_trip_level_q <= sgd_pkg::TRIP_SEL_RESET;
      end else if (ce) begin
         gate_q <= gate_d;
         gate_fault_q <= gf_d;
         oc_fault_q <= oc_d;
         fault_n_q <= ~(|gf_d || |oc_d); // [RL15]
         gate_current_select_q <= cur_d;
         overcurrent_trip_level_q <= trip_d;
      end
   end
endmodule

// File: dv/sgd_checker.sv
module sgd_checker #(
   parameter int unsigned CNT_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic fault_clear_in,
   input wire logic [CNT_W-1:0] drive_window_cycles,
   input sgd_pkg::sgd_phase_s [sgd_pkg::PHASES-1:0] gate_q,
   input wire logic [3:0] gate_current_select_q,
   input wire logic [5:0] gate_fault_q,
   input wire logic [5:0] oc_fault_q,
   input wire logic fault_n_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [4:0] since_clr_q;
   logic [CNT_W:0] dc_len_q;
   logic on_prev_q;
   logic [11:0] all_f;
   logic both_on;
   assign all_f = {gate_fault_q, oc_fault_q};
   always_comb begin
      both_on = 1'b0;
      for (int p = 0; p < sgd_pkg::PHASES; p++) begin
         both_on = both_on | (gate_q[p].hs.on & gate_q[p].ls.on);
      end
   end
   // clear is deglitched, so a drop may trail the pin by several cycles
   always_ff @(posedge ref_clk) begin
      since_clr_q <= fault_clear_in ? 5'h0 : (rst ? 5'h1f : since_clr_q + {4'h0, ~&since_clr_q});
      // a new transition restarts the window even if drive current never dropped
      dc_len_q <= !gate_q[0].hs.drive_current ? '0 :
                  (gate_q[0].hs.on != on_prev_q) ? (CNT_W+1)'(1) : dc_len_q + 1'b1;
      on_prev_q <= gate_q[0].hs.on;
   end
   property p_no_shoot; !both_on; endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("both gates of a phase on");
   property p_rst_vals; $past(rst) |-> gate_current_select_q == 4'hf && fault_n_q; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
   property p_fault_pin; fault_n_q == !(|all_f); endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin mismatch");
   property p_sticky; !$past(rst) && |($past(all_f) & ~all_f) |-> since_clr_q < 5'h14; endproperty
   a_sticky: assert property (p_sticky) else $error("fault dropped without clear");
   property p_pulldown;
      gate_q[0].hs.drive_current == gate_q[0].ls.strong_pulldown &&
      gate_q[0].ls.drive_current == gate_q[0].hs.strong_pulldown;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pulldown not paired");
   property p_win_len; $fell(gate_q[0].hs.drive_current) |-> dc_len_q <= drive_window_cycles; endproperty
   a_win_len: assert property (p_win_len) else $error("drive window too long");
   property p_dead_gap; $fell(gate_q[0].hs.on) |-> !gate_q[0].ls.on [*2]; endproperty
   a_dead_gap: assert property (p_dead_gap) else $error("no dead time");
   property p_gfault;
      $rose(gate_fault_q[1]) |-> $past(gate_q[0].hs.drive_current) || $past(gate_q[0].hs.drive_current, 2);
   endproperty
   a_gfault: assert property (p_gfault) else $error("gate fault off window end");
   property p_oc_on; $rose(oc_fault_q[1]) |-> $past(gate_q[0].hs.on); endproperty
   a_oc_on: assert property (p_oc_on) else $error("overcurrent while gate off");
endmodule

bind sgd_sequencer sgd_checker #(.CNT_W(CNT_W)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .ce(ce), .fault_clear_in(fault_clear_in),
   .drive_window_cycles(drive_window_cycles), .gate_q(gate_q),
   .gate_current_select_q(gate_current_select_q), .gate_fault_q(gate_fault_q),
   .oc_fault_q(oc_fault_q), .fault_n_q(fault_n_q)
);

// File: dv/sgd_bridge_model.sv
module sgd_bridge_model (
   input wire logic ref_clk,
   input sgd_pkg::sgd_phase_s [sgd_pkg::PHASES-1:0] gate_q,
   input wire logic [5:0] stuck_low,
   output logic [5:0] vgs_high_in
);
   logic [5:0] on_vec;
   logic [5:0] lag_q;
   always_comb begin
      for (int p = 0; p < sgd_pkg::PHASES; p++) begin
         on_vec[2*p+1] = gate_q[p].hs.on;
         on_vec[2*p] = gate_q[p].ls.on;
      end
   end
   // two-cycle gate charge, shorter than any window the bench sets
   always_ff @(posedge ref_clk) begin
      lag_q <= on_vec;
      vgs_high_in <= lag_q & on_vec & ~stuck_low;
   end
endmodule

// File: dv/sgd_sequencer_tb.sv
module sgd_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic serial_variant = 1'b1;
   logic [5:0] pwm_in = '0;
   logic fault_clear_in = 1'b0;
   logic [5:0] vgs_high_in;
   logic [5:0] stuck_low = '0;
   logic [2:0] highside_drain_sense_over = '0;
   logic [2:0] shunt_positive_sense_over = '0;
   logic [2:0] shunt_negative_sense_over = '0;
   logic lowside_monitor_reference_select = 1'b0;
   logic [3:0] gate_current_select_reg = 4'h9;
   logic [2:0] gate_current_select_pin = '0;
   logic [3:0] trip_level_reg = 4'hb;
   logic [2:0] threshold_select_pin = '0;
   logic [7:0] drive_window_cycles = 8'h06;
   logic [7:0] dead_time_cycles = 8'h03;
   logic [7:0] overcurrent_deglitch_time = 8'h06;
   logic [1:0] oc_fault_mode = sgd_pkg::OC_MODE_REPORT;
   sgd_pkg::sgd_phase_s [sgd_pkg::PHASES-1:0] gate_q;
   logic [3:0] gate_current_select_q;
   logic [3:0] overcurrent_trip_level_q;
   logic [5:0] gate_fault_q;
   logic [5:0] oc_fault_q;
   logic fault_n_q;
   logic [5:0] probe;
   int mismatches = 0;
   int checks_done = 0;
   int n;
   int g_ser;
   int g_hw;
   sgd_sequencer dut_u (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .serial_variant(serial_variant),
      .pwm_in(pwm_in), .fault_clear_in(fault_clear_in), .vgs_high_in(vgs_high_in),
      .highside_drain_sense_over(highside_drain_sense_over),
      .shunt_positive_sense_over(shunt_positive_sense_over),
      .shunt_negative_sense_over(shunt_negative_sense_over),
      .lowside_monitor_reference_select(lowside_monitor_reference_select),
      .gate_current_select_reg(gate_current_select_reg),
      .gate_current_select_pin(gate_current_select_pin),
      .trip_level_reg(trip_level_reg), .threshold_select_pin(threshold_select_pin),
      .drive_window_cycles(drive_window_cycles), .dead_time_cycles(dead_time_cycles),
      .overcurrent_deglitch_time(overcurrent_deglitch_time),
      .oc_fault_mode(oc_fault_mode), .gate_q(gate_q),
      .gate_current_select_q(gate_current_select_q),
      .overcurrent_trip_level_q(overcurrent_trip_level_q),
      .gate_fault_q(gate_fault_q), .oc_fault_q(oc_fault_q), .fault_n_q(fault_n_q)
   );
   sgd_bridge_model bridge_u (
      .ref_clk(ref_clk), .gate_q(gate_q), .stuck_low(stuck_low), .vgs_high_in(vgs_high_in)
   );
   assign probe = {fault_n_q, |oc_fault_q, |gate_fault_q, gate_q[0].hs.drive_current,
                   gate_q[0].ls.on, gate_q[0].hs.on};
   always #5 ref_clk = ~ref_clk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_bit(input int i, input logic v);
      n = 0;
      while (probe[i] !== v) begin
         @(posedge ref_clk);
         #1 n++;
         if (n > 300) begin
            mismatches++;
            report_and_stop;
         end
      end
   endtask
   task automatic cmd(input logic [5:0] v);
      @(posedge ref_clk);
      pwm_in <= v;
   endtask
   task automatic codes(input logic [3:0] cur, input logic [3:0] trip);
      n = 0;
      while (!(gate_current_select_q === cur && overcurrent_trip_level_q === trip) && n < 40) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check(gate_current_select_q, cur);
      check(overcurrent_trip_level_q, trip);
      if (n == 40) begin
         mismatches++;
         report_and_stop;
      end
   endtask
   task automatic t_codes;
      codes(4'h9, 4'hb);
      @(posedge ref_clk);
      serial_variant <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         gate_current_select_pin <= i[2:0];
         threshold_select_pin <= 3'(7 - i);
         codes(sgd_pkg::CURRENT_HW_MAP[i > 6 ? 6 : i], sgd_pkg::TRIP_HW_MAP[i > 0 ? 7 - i : 6]);
      end
      @(posedge ref_clk);
      serial_variant <= 1'b1;
   endtask
   task automatic handover(output int gap);
      cmd(6'h02);
      wait_bit(0, 1'b1);
      check(gate_q[0].ls.strong_pulldown, 1);
      wait_bit(2, 1'b0);
      check(n, drive_window_cycles);
      check(gate_fault_q, 0);
      cmd(6'h01);
      wait_bit(0, 1'b0);
      wait_bit(1, 1'b1);
      gap = n;
      cmd(6'h00);
      wait_bit(1, 1'b0);
   endtask
   task automatic t_early;
      @(posedge ref_clk);
      drive_window_cycles <= 8'd40;
      // gate never charges: the new command restarts the window for turn-off, which ends with the gate off, so no fault
      stuck_low <= 6'h02;
      cmd(6'h02);
      wait_bit(0, 1'b1);
      cmd(6'h00);
      wait_bit(0, 1'b0);
      check(n < 20, 1);
      wait_bit(2, 1'b0);
      check(gate_fault_q, 0);
      @(posedge ref_clk);
      drive_window_cycles <= 8'h06;
      stuck_low <= '0;
   endtask
   task automatic clear_faults;
      @(posedge ref_clk);
      fault_clear_in <= 1'b1;
      wait_bit(5, 1'b1);
      @(posedge ref_clk);
      fault_clear_in <= 1'b0;
      #1 check(gate_fault_q | oc_fault_q, 0);
   endtask
   task automatic t_glitch;
      cmd(6'h02);
      repeat (3) @(posedge ref_clk);
      pwm_in <= 6'h00;
      n = 0;
      repeat (20) begin
         @(posedge ref_clk);
         #1 n += probe[0];
      end
      check(n, 0);
   endtask
   task automatic t_modes;
      @(posedge ref_clk);
      oc_fault_mode <= sgd_pkg::OC_MODE_LATCH;
      cmd(6'h02);
      wait_bit(0, 1'b1);
      @(posedge ref_clk);
      highside_drain_sense_over <= 3'h1;
      // latched overcurrent must force the gate off with no new command
      wait_bit(0, 1'b0);
      check(oc_fault_q, 8'h02);
      @(posedge ref_clk);
      oc_fault_mode <= sgd_pkg::OC_MODE_OFF;
      clear_faults;
      wait_bit(0, 1'b1);
      repeat (20) @(posedge ref_clk);
      #1 check(oc_fault_q, 0);
      cmd(6'h00);
      highside_drain_sense_over <= 3'h0;
      wait_bit(0, 1'b0);
      @(posedge ref_clk);
      oc_fault_mode <= sgd_pkg::OC_MODE_REPORT;
   endtask
   task automatic t_gfault;
      @(posedge ref_clk);
      stuck_low <= 6'h02;
      cmd(6'h02);
      wait_bit(5, 1'b0);
      check(gate_fault_q, 8'h02);
      cmd(6'h00);
      wait_bit(0, 1'b0);
      check(gate_fault_q, 8'h02);
      stuck_low <= '0;
      clear_faults;
   endtask
   task automatic t_oc;
      cmd(6'h02);
      wait_bit(0, 1'b1);
      @(posedge ref_clk);
      highside_drain_sense_over <= 3'h1;
      repeat (4) @(posedge ref_clk);
      highside_drain_sense_over <= 3'h0;
      repeat (12) @(posedge ref_clk);
      #1 check(oc_fault_q, 0);
      @(posedge ref_clk);
      highside_drain_sense_over <= 3'h1;
      wait_bit(4, 1'b1);
      check(n > 6 && n < 12, 1);
      check(oc_fault_q, 8'h02);
      cmd(6'h00);
      highside_drain_sense_over <= 3'h0;
      clear_faults;
   endtask
   task automatic t_lowside_monitor_reference_select;
      for (int s = 0; s < 2; s++) begin
         @(posedge ref_clk);
         lowside_monitor_reference_select <= s[0];
         shunt_positive_sense_over <= {2'h0, s[0]};
         shunt_negative_sense_over <= {2'h0, ~s[0]};
         cmd(6'h01);
         repeat (30) @(posedge ref_clk);
         #1 check(oc_fault_q, 0);
         @(posedge ref_clk);
         shunt_positive_sense_over <= {2'h0, ~s[0]};
         shunt_negative_sense_over <= {2'h0, s[0]};
         wait_bit(4, 1'b1);
         check(oc_fault_q, 8'h01);
         cmd(6'h00);
         shunt_positive_sense_over <= '0;
         shunt_negative_sense_over <= '0;
         clear_faults;
      end
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 check(gate_q, 0);
      check(overcurrent_trip_level_q, 8'h07);
      @(posedge ref_clk);
      rst <= 1'b0;
      t_codes;
      handover(g_ser);
      @(posedge ref_clk);
      serial_variant <= 1'b0;
      handover(g_hw);
      check(g_ser - g_hw, 8'h03);
      check(g_hw > 1, 1);
      @(posedge ref_clk);
      serial_variant <= 1'b1;
      t_early;
      t_gfault;
      t_oc;
      t_lowside_monitor_reference_select;
      t_glitch;
      t_modes;
      report_and_stop;
   end
endmodule
